// [include/tmr_map.svh]
// Register map, field positions, reset values and timing counts of the timer.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// Register indices; byte address is four times the index
`define TMR_IDX_CONTROL      8'hB0
`define TMR_IDX_COUNTER      8'hB2
`define TMR_IDX_COMPARE      8'hB3
`define TMR_IDX_STATUS       8'hB6

// Control register fields
`define TMR_CTRL_FORCE       7
`define TMR_CTRL_WAVE_LOW    6
`define TMR_CTRL_COM_HIGH    5
`define TMR_CTRL_COM_LOW     4
`define TMR_CTRL_WAVE_HIGH   3
`define TMR_CTRL_CS_HIGH     2

// Status register fields
`define TMR_STAT_EXT_CLK     4
`define TMR_STAT_ASYNC_SEL   3
`define TMR_STAT_CNT_BUSY    2
`define TMR_STAT_CMP_BUSY    1
`define TMR_STAT_CTL_BUSY    0

// Reset values
`define TMR_RST_CONTROL      8'h00
`define TMR_RST_COUNTER      8'h00
`define TMR_RST_COMPARE      8'h00
`define TMR_RST_STATUS       8'h00

// Counter limits and transfer latency in source clock edges
`define TMR_MAX              8'hFF
`define TMR_BOTTOM           8'h00
`define TMR_XFER_EDGES       2'h2

`endif

// [include/tmr_pkg.sv]
// Types and decode helpers shared by the timer design files.
// Assumes tmr_map.svh is on the include path.
`include "tmr_map.svh"

package tmr_pkg;

  typedef enum logic [1:0] {
    TMR_MODE_NORMAL,
    TMR_MODE_PHASE_PWM,
    TMR_MODE_CLEAR_ON_MATCH,
    TMR_MODE_FAST_PWM
  } tmr_mode_t;

  typedef enum logic [2:0] {
    TMR_REG_CONTROL,
    TMR_REG_COUNTER,
    TMR_REG_COMPARE,
    TMR_REG_STATUS,
    TMR_REG_NONE
  } tmr_reg_t;

  function automatic logic [9:0] tmr_byte_addr(input logic [7:0] idx);
    tmr_byte_addr = {idx, 2'b00};
  endfunction : tmr_byte_addr

endpackage : tmr_pkg

// [include/tmr_tick_if.sv]
// Carrier between the timer core and its prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface tmr_tick_if;
  logic       src_tick;     // One tick of the timer source clock
  logic [2:0] clock_select; // Prescaler tap choice
  logic       count_tick;   // Enabled counter tick

  modport core      (output src_tick, output clock_select, input count_tick);
  modport prescaler (input src_tick, input clock_select, output count_tick);
endinterface : tmr_tick_if

`default_nettype wire

// [hw/tmr_prescaler.sv]
// Clock-select prescaler: divides source ticks by the chosen tap.
// Assumes src_tick is a one-cycle pulse on pclk.
`timescale 1ns/1ps
`default_nettype none

module tmr_prescaler
  import tmr_pkg::*;
(
  input  wire logic pclk,    // System clock
  input  wire logic presetn, // Async reset, active low
  tmr_tick_if.prescaler tick // Tick carrier
);

  logic [9:0] div_count;

  // Mask of low prescaler bits that must be all ones for a tap
  function automatic logic [9:0] tap_mask(input logic [2:0] sel);
    unique case (sel)
      3'h2:    tap_mask = 10'h007;
      3'h3:    tap_mask = 10'h01F;
      3'h4:    tap_mask = 10'h03F;
      3'h5:    tap_mask = 10'h07F;
      3'h6:    tap_mask = 10'h0FF;
      3'h7:    tap_mask = 10'h3FF;
      default: tap_mask = 10'h000;
    endcase
  endfunction : tap_mask

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 10'h000;
    end else if (tick.src_tick) begin
      div_count <= div_count + 10'h001;
    end
  end

  always_comb begin
    if (tick.clock_select == 3'h0) begin
      tick.count_tick = 1'b0; // RULE_13
    end else begin
      tick.count_tick = tick.src_tick && ((div_count & tap_mask(tick.clock_select)) == tap_mask(tick.clock_select)); // RULE_13
    end
  end

endmodule : tmr_prescaler

`default_nettype wire

// [hw/tmr_async_timer.sv]
// 8-bit timer/counter with one compare output, APB register access.
// Assumes an APB master on pclk; timer_osc_pin is asynchronous to pclk.
//
// Summary of operation
// RULE_01: Force strobe applies match in non-PWM modes
// RULE_02: Forced match raises no event, no clear
// RULE_03: Force strobe bit always reads zero
// RULE_04: Software writes strobe zero in PWM modes
// RULE_05: Mode bits 6,3 select four modes, top
// RULE_06: Compare update and overflow timing per mode
// RULE_07: Nonzero output mode overrides port pin
// RULE_08: Non-PWM: off, toggle, clear, set on match
// RULE_09: Fast PWM: non-inverting and inverting encodings
// RULE_10: Fast PWM compare at top: bottom only
// RULE_11: Phase PWM: clear up, set down encodings
// RULE_12: Phase PWM compare at top: act at top
// RULE_13: Clock select stops or divides source clock
// RULE_14: Counter register reads and writes counter
// RULE_15: Counter write blocks next tick's match
// RULE_16: Compare register continuously compared with counter
// RULE_17: Status register layout and reset zero
// RULE_18: Async select picks oscillator pin clock
// RULE_19: Async writes set busy until transferred
// RULE_20: Counter reads live, others read temporary
// RULE_21: External clock enable buffers oscillator input
// RULE_22: Counter wraps up, or counts up-down
// RULE_23: Software avoids writes while busy
`timescale 1ns/1ps
`default_nettype none

module tmr_async_timer
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              pclk,             // System clock, 200 MHz
  input  wire logic              presetn,          // Async reset, active low
  input  wire logic              psel,             // APB select
  input  wire logic              penable,          // APB enable
  input  wire logic              pwrite,           // APB direction
  input  wire logic [ADDR_W-1:0] paddr,            // APB byte address
  input  wire logic [31:0]       pwdata,           // APB write data
  output logic      [31:0]       prdata,           // APB read data
  output logic                   pready,           // APB ready
  output logic                   pslverr,          // APB error, unmapped
  input  wire logic              timer_osc_pin,    // Timer oscillator input
  input  wire logic              port_dir_bit,     // Port direction bit of pin
  input  wire logic              port_data_bit,    // Normal port output value
  output logic                   compare_pin_out,  // Pin output value
  output logic                   compare_pin_oe,   // Pin driver enable
  output logic                   osc_ext_clock_en, // External clock buffer on
  output logic                   overflow_event,   // Overflow flag set pulse
  output logic                   compare_event     // Compare flag set pulse
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tmr_tick_if tick ();

  logic [7:0] control_tmp;
  logic [6:0] control_act;
  logic [7:0] counter_tmp;
  logic [7:0] compare_tmp;
  logic [7:0] compare_buf;
  logic [7:0] compare_act;
  logic [7:0] counter_value;
  logic       count_down;
  logic       block_match;
  logic       force_req;
  logic       wave_out;
  logic       external_clock_enable;
  logic       async_clock_select;
  logic       osc_meta;
  logic       osc_sync;
  logic       osc_prev;
  logic [2:0] pend;
  logic [1:0] edge_cnt [3];
  logic [2:0] xfer;
  logic [2:0] wr_hit;
  logic       wr_access;
  tmr_reg_t   sel_reg;
  tmr_mode_t  mode;
  logic [1:0] com;
  logic       hit;
  logic       top_ignore;
  logic [7:0] next_counter;
  logic       next_down;
  logic       next_wave;
  logic       next_ovf;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic tmr_reg_t decode(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(tmr_byte_addr(`TMR_IDX_CONTROL))) begin
      decode = TMR_REG_CONTROL;
    end else if (addr == ADDR_W'(tmr_byte_addr(`TMR_IDX_COUNTER))) begin
      decode = TMR_REG_COUNTER;
    end else if (addr == ADDR_W'(tmr_byte_addr(`TMR_IDX_COMPARE))) begin
      decode = TMR_REG_COMPARE;
    end else if (addr == ADDR_W'(tmr_byte_addr(`TMR_IDX_STATUS))) begin
      decode = TMR_REG_STATUS;
    end else begin
      decode = TMR_REG_NONE;
    end
  endfunction : decode

  // Output action on a non-PWM match
  function automatic logic nonpwm_action(input logic [1:0] cm, input logic cur);
    unique case (cm)
      2'b01:   nonpwm_action = ~cur;
      2'b10:   nonpwm_action = 1'b0;
      2'b11:   nonpwm_action = 1'b1;
      default: nonpwm_action = cur;
    endcase
  endfunction : nonpwm_action

  function automatic logic is_pwm(input logic [7:0] ctl);
    is_pwm = ctl[`TMR_CTRL_WAVE_LOW];
  endfunction : is_pwm

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign sel_reg   = decode(paddr);
  assign wr_access = psel && penable && pready && pwrite;
  assign wr_hit[`TMR_STAT_CNT_BUSY] = wr_access && (sel_reg == TMR_REG_COUNTER);
  assign wr_hit[`TMR_STAT_CMP_BUSY] = wr_access && (sel_reg == TMR_REG_COMPARE);
  assign wr_hit[`TMR_STAT_CTL_BUSY] = wr_access && (sel_reg == TMR_REG_CONTROL);

  // One wait-free access phase: ready rises in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (sel_reg == TMR_REG_NONE);
      if (psel && !penable && !pwrite) begin
        unique case (sel_reg)
          TMR_REG_CONTROL: prdata <= {25'h0, control_tmp[6:0]}; // RULE_03 RULE_20
          TMR_REG_COUNTER: prdata <= {24'h0, counter_value};    // RULE_14 RULE_20
          TMR_REG_COMPARE: prdata <= {24'h0, compare_tmp};      // RULE_20
          TMR_REG_STATUS:  prdata <= {27'h0, external_clock_enable, async_clock_select,
                                      pend & {3{async_clock_select}}}; // RULE_17 RULE_19
          default:         prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Temporary storage written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_tmp <= `TMR_RST_CONTROL;
      counter_tmp <= `TMR_RST_COUNTER;
      compare_tmp <= `TMR_RST_COMPARE;
    end else begin
      if (wr_hit[`TMR_STAT_CTL_BUSY]) begin
        control_tmp <= pwdata[7:0];
      end
      if (wr_hit[`TMR_STAT_CNT_BUSY]) begin
        counter_tmp <= pwdata[7:0];
      end
      if (wr_hit[`TMR_STAT_CMP_BUSY]) begin
        compare_tmp <= pwdata[7:0];
      end
    end
  end

  // Status register control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_clock_enable <= 1'(`TMR_RST_STATUS >> `TMR_STAT_EXT_CLK);
      async_clock_select    <= 1'(`TMR_RST_STATUS >> `TMR_STAT_ASYNC_SEL);
    end else if (wr_access && sel_reg == TMR_REG_STATUS) begin
      external_clock_enable <= pwdata[`TMR_STAT_EXT_CLK];   // RULE_17
      async_clock_select    <= pwdata[`TMR_STAT_ASYNC_SEL]; // RULE_17
    end
  end

  // ****************************************************************
  // Source clock selection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= timer_osc_pin;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign tick.src_tick     = async_clock_select ? (osc_sync && !osc_prev) : 1'b1; // RULE_18
  assign tick.clock_select = control_act[`TMR_CTRL_CS_HIGH:0];

  tmr_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick.prescaler)
  );

  // ****************************************************************
  // Temporary to destination transfer
  // ****************************************************************
  for (genvar i = 0; i < 3; i++) begin : g_xfer
    assign xfer[i] = pend[i] && (!async_clock_select ||
                     (tick.src_tick && edge_cnt[i] == `TMR_XFER_EDGES - 2'h1)); // RULE_19

    // New write wins over a transfer in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend[i]     <= 1'b0;
        edge_cnt[i] <= 2'h0;
      end else if (wr_hit[i]) begin
        pend[i]     <= 1'b1; // RULE_19
        edge_cnt[i] <= 2'h0;
      end else if (xfer[i]) begin
        pend[i]     <= 1'b0; // RULE_19
        edge_cnt[i] <= 2'h0;
      end else if (pend[i] && tick.src_tick) begin
        edge_cnt[i] <= edge_cnt[i] + 2'h1;
      end
    end
  end

  // Control destination and forced compare request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_act <= 7'(`TMR_RST_CONTROL);
      force_req   <= 1'b0;
    end else if (xfer[`TMR_STAT_CTL_BUSY]) begin
      control_act <= control_tmp[6:0];
      force_req   <= control_tmp[`TMR_CTRL_FORCE] && !is_pwm(control_tmp); // RULE_01
    end else begin
      force_req   <= 1'b0;
    end
  end

  // Compare buffer and active compare value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_buf <= `TMR_RST_COMPARE;
    end else if (xfer[`TMR_STAT_CMP_BUSY]) begin
      compare_buf <= compare_tmp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_act <= `TMR_RST_COMPARE;
    end else begin
      unique case (mode)
        TMR_MODE_NORMAL, TMR_MODE_CLEAR_ON_MATCH: begin
          compare_act <= compare_buf; // RULE_06
        end
        TMR_MODE_FAST_PWM: begin
          if (tick.count_tick && counter_value == `TMR_MAX) begin
            compare_act <= compare_buf; // RULE_06
          end
        end
        TMR_MODE_PHASE_PWM: begin
          if (tick.count_tick && !count_down && counter_value == `TMR_MAX) begin
            compare_act <= compare_buf; // RULE_06
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Counting and waveform
  // ****************************************************************
  assign mode       = tmr_mode_t'({control_act[`TMR_CTRL_WAVE_HIGH], control_act[`TMR_CTRL_WAVE_LOW]}); // RULE_05
  assign com        = control_act[`TMR_CTRL_COM_HIGH:`TMR_CTRL_COM_LOW];
  assign hit        = tick.count_tick && (counter_value == compare_act) && !block_match; // RULE_15 RULE_16
  assign top_ignore = (compare_act == `TMR_MAX) && com[1];

  always_comb begin
    next_counter = counter_value;
    next_down    = count_down;
    next_wave    = wave_out;
    next_ovf     = 1'b0;
    if (tick.count_tick) begin
      unique case (mode)
        TMR_MODE_NORMAL: begin
          next_counter = counter_value + 8'h01; // RULE_22
          next_ovf     = (counter_value == `TMR_MAX); // RULE_06
          if (hit) begin
            next_wave = nonpwm_action(com, wave_out); // RULE_08
          end
        end
        TMR_MODE_CLEAR_ON_MATCH: begin
          next_counter = hit ? `TMR_BOTTOM : counter_value + 8'h01; // RULE_05
          next_ovf     = (counter_value == `TMR_MAX); // RULE_06
          if (hit) begin
            next_wave = nonpwm_action(com, wave_out); // RULE_08
          end
        end
        TMR_MODE_FAST_PWM: begin
          next_counter = counter_value + 8'h01; // RULE_22
          next_ovf     = (counter_value == `TMR_MAX); // RULE_06
          if (hit && !top_ignore && com[1]) begin
            next_wave = com[0]; // RULE_09 RULE_10
          end
          if (counter_value == `TMR_MAX && com[1]) begin
            next_wave = !com[0]; // RULE_09 RULE_10
          end
        end
        TMR_MODE_PHASE_PWM: begin
          if (!count_down) begin
            if (counter_value == `TMR_MAX) begin
              next_down    = 1'b1; // RULE_22
              next_counter = `TMR_MAX - 8'h01;
            end else begin
              next_counter = counter_value + 8'h01;
            end
          end else begin
            if (counter_value == `TMR_BOTTOM) begin
              next_down    = 1'b0; // RULE_22
              next_counter = `TMR_BOTTOM + 8'h01;
              next_ovf     = 1'b1; // RULE_06
            end else begin
              next_counter = counter_value - 8'h01;
            end
          end
          if (hit && !top_ignore && com[1]) begin
            next_wave = count_down ? !com[0] : com[0]; // RULE_11
          end
          if (top_ignore && !count_down && counter_value == `TMR_MAX) begin
            next_wave = !com[0]; // RULE_12
          end
        end
      endcase
    end
    if (force_req) begin
      next_wave = nonpwm_action(com, next_wave); // RULE_01 RULE_02
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= `TMR_RST_COUNTER;
      count_down    <= 1'b0;
    end else if (xfer[`TMR_STAT_CNT_BUSY]) begin
      counter_value <= counter_tmp; // RULE_14
    end else begin
      counter_value <= next_counter;
      count_down    <= next_down;
    end
  end

  // Write to counter masks the match on the following tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_match <= 1'b0;
    end else if (xfer[`TMR_STAT_CNT_BUSY]) begin
      block_match <= 1'b1; // RULE_15
    end else if (tick.count_tick) begin
      block_match <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out <= 1'b0;
    end else begin
      wave_out <= next_wave;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_event <= 1'b0;
      compare_event  <= 1'b0;
    end else begin
      overflow_event <= next_ovf && !xfer[`TMR_STAT_CNT_BUSY];
      compare_event  <= hit && !xfer[`TMR_STAT_CNT_BUSY]; // RULE_02 RULE_16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin_out  <= 1'b0;
      compare_pin_oe   <= 1'b0;
      osc_ext_clock_en <= 1'b0;
    end else begin
      compare_pin_out  <= (com != 2'b00) ? next_wave : port_data_bit; // RULE_07
      compare_pin_oe   <= port_dir_bit; // RULE_07
      osc_ext_clock_en <= external_clock_enable && async_clock_select; // RULE_21
    end
  end

endmodule : tmr_async_timer

`default_nettype wire

// [verification/tmr_async_timer_monitor.sv]
// Concurrent checks of the timer's APB answers and pin outputs.
// Assumes a bind to tmr_async_timer; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tmr_async_timer_monitor #(
  parameter int ADDR_W = 12
)(
  input wire logic              pclk,             // Clock
  input wire logic              presetn,          // Reset, low
  input wire logic              psel,             // Select
  input wire logic              penable,          // Enable
  input wire logic              pwrite,           // Direction
  input wire logic [ADDR_W-1:0] paddr,            // Address
  input wire logic [31:0]       pwdata,           // Write data
  input wire logic [31:0]       prdata,           // Read data
  input wire logic              pready,           // Ready
  input wire logic              pslverr,          // Error
  input wire logic              port_dir_bit,     // Direction bit
  input wire logic              compare_pin_oe,   // Driver enable
  input wire logic              osc_ext_clock_en, // Clock buffer on
  input wire logic              overflow_event    // Overflow pulse
);
  // ****************
  // Bus and pin checks
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  sequence rd_s(a); access_s ##0 (!pwrite && paddr == a); endsequence
  sequence st_wr_s; access_s ##0 (pwrite && paddr == 'h2D8); endsequence
  ready_next_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  strobe_zero_a: assert property (rd_s('h2C0) |-> prdata[31:7] == '0)
    else $error("strobe bit read as one");
  status_bits_a: assert property (rd_s('h2D8) |-> prdata[31:5] == '0)
    else $error("status upper bits not zero");
  ext_on_a: assert property (st_wr_s ##0 pwdata[4:3] == 2'h3 |-> ##[1:3] osc_ext_clock_en)
    else $error("clock buffer not enabled");
  ext_off_a: assert property (st_wr_s ##0 pwdata[4:3] != 2'h3 |-> ##[1:3] !osc_ext_clock_en)
    else $error("clock buffer not disabled");
  pin_oe_a: assert property ($past(presetn) |-> compare_pin_oe == $past(port_dir_bit))
    else $error("driver enable off direction bit");
  ovf_pulse_a: assert property (overflow_event |=> !overflow_event)
    else $error("overflow pulse too long");
  unmapped_a: assert property (access_s ##0 !(paddr inside {'h2C0, 'h2C8, 'h2CC, 'h2D8}) |-> pslverr)
    else $error("unmapped access without error");
endmodule : tmr_async_timer_monitor

bind tmr_async_timer tmr_async_timer_monitor #(.ADDR_W(ADDR_W)) u_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .port_dir_bit, .compare_pin_oe, .osc_ext_clock_en, .overflow_event
);
`default_nettype wire

// [verification/tmr_async_timer_bench.sv]
// Self-checking bench for the timer: APB register tasks and pin checks.
// Assumes the timer and its bound checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tmr_async_timer_bench;
  // ****************
  // Stimulus and checks
  // ****************
  localparam logic [11:0] ctl_a = 12'h2C0;
  localparam logic [11:0] cnt_a = 12'h2C8;
  localparam logic [11:0] cmp_a = 12'h2CC;
  localparam logic [11:0] sta_a = 12'h2D8;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, r0;
  logic        pready, pslverr, err, osc = 1'b0, dir = 1'b0, pdat = 1'b0, pin, oe, ext, ovf, cev;
  int          n_fail = 0, cmp_count = 0, cyc = 0, ev = 0, ovc = 0, p, e0, o0;
  int          div [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  int          pctl [3] = '{32'h01, 32'h49, 32'h41};
  int          plen [3] = '{256, 256, 510};
  logic [7:0]  fctl [6] = '{8'hB0, 8'hA0, 8'h90, 8'h90, 8'hB0, 8'h68};
  logic        fexp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  tmr_async_timer dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_pin(osc), .port_dir_bit(dir), .port_data_bit(pdat), .compare_pin_out(pin),
    .compare_pin_oe(oe), .osc_ext_clock_en(ext), .overflow_event(ovf), .compare_event(cev)
  );

  always #2.5 pclk = ~pclk;

  // Oscillator pin at a twentieth of pclk, event counts and timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 9) osc <= ~osc;
    if (cev === 1'b1) ev <= ev + 1;
    if (ovf === 1'b1) ovc <= ovc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask : waitc

  // Edges from one overflow pulse to the next
  task automatic period(output int n);
    int k;
    k = 0;
    while (ovf !== 1'b1 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
    n = 1;
    while (ovf !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
  endtask : period

  task automatic high(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin === 1'b1) h++;
    end
  endtask : high

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ctl_a, 32'h0);
    rchk(sta_a, 32'h0);
    rchk(cnt_a, 32'h0);
    rchk(cmp_a, 32'h0);
    $display("test reset done");
    dir <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, ctl_a, {24'h0, fctl[i]});
      waitc(4);
      chk(pin, fexp[i]);
      rchk(ctl_a, {24'h0, fctl[i] & 8'h7F});
    end
    chk(oe, 1'b1);
    rchk(ctl_a, 32'h68);
    chk(ev, 0);
    xfer(1'b1, ctl_a, 32'h0);
    pdat <= 1'b1;
    waitc(4);
    chk(pin, 1'b1);
    $display("test force done");
    xfer(1'b1, cnt_a, 32'h5A);
    waitc(2);
    rchk(cnt_a, 32'h5A);
    xfer(1'b1, cmp_a, 32'hFFFFFFA5);
    rchk(cmp_a, 32'hA5);
    xfer(1'b0, 12'h004, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test access done");
    for (int i = 1; i < 8; i++) begin
      xfer(1'b1, ctl_a, i);
      xfer(1'b1, cnt_a, 32'h0);
      waitc(8 * div[i]);
      xfer(1'b0, cnt_a, 32'h0);
      chk(rd[7:0] >= 8'h07 && rd[7:0] <= 8'h0B, 1'b1);
    end
    xfer(1'b1, ctl_a, 32'h0);
    xfer(1'b0, cnt_a, 32'h0);
    r0 = rd;
    waitc(40);
    rchk(cnt_a, r0);
    $display("test prescaler done");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ctl_a, pctl[i]);
      waitc(4);
      period(p);
      chk(p, plen[i]);
    end
    xfer(1'b1, ctl_a, 32'h09);
    xfer(1'b1, cmp_a, 32'h10);
    xfer(1'b1, cnt_a, 32'h0);
    waitc(10);
    e0 = ev;
    o0 = ovc;
    waitc(340);
    chk(ev - e0, 20);
    chk(ovc - o0, 0);
    xfer(1'b1, cnt_a, 32'h10);
    waitc(4);
    rchk(cnt_a, 32'h14);
    xfer(1'b1, cmp_a, 32'h40);
    xfer(1'b1, ctl_a, 32'h69);
    waitc(300);
    high(512, p);
    chk(p >= 126 && p <= 132, 1'b1);
    xfer(1'b1, cmp_a, 32'h80);
    xfer(1'b1, ctl_a, 32'h61);
    waitc(600);
    high(510, p);
    chk(p >= 252 && p <= 260, 1'b1);
    $display("test modes done");
    xfer(1'b1, ctl_a, 32'h01);
    xfer(1'b1, sta_a, 32'hFF);
    rchk(sta_a, 32'h18);
    chk(ext, 1'b1);
    xfer(1'b1, cmp_a, 32'h33);
    rchk(sta_a, 32'h1A);
    waitc(100);
    rchk(sta_a, 32'h18);
    rchk(cmp_a, 32'h33);
    xfer(1'b0, cnt_a, 32'h0);
    r0 = rd;
    waitc(40);
    xfer(1'b0, cnt_a, 32'h0);
    chk(rd[7:0] - r0[7:0] >= 8'h01 && rd[7:0] - r0[7:0] <= 8'h03, 1'b1);
    xfer(1'b1, sta_a, 32'h10);
    waitc(2);
    chk(ext, 1'b0);
    $display("test async done");
    end_of_test();
  end
endmodule : tmr_async_timer_bench
`default_nettype wire
